// ---- supply_status_trigger_control.sv ----
// Behaviour
// (R01) questionable bits: ov0 oc1 phase2 program3 temp4 fuse5 alarm7 lockout8 remote9
// (R02) version query returns firmware and hardware revision together
// (R03) errors queue first-in first-out; each error query pops oldest code
// (R04) empty queue answers code 0, no error
// (R05) on overflow the last queue entry becomes -350
// (R06) error code range sets event status bit 5, 4, 3 or 2
// (R07) codes used: -100, -102, -108, -222, -400
// (R08) trigger while armed applies pending voltage and current levels
// (R09) after trigger clear operation register; continuous mode re-arms at once
// (R10) triggers ignored while not armed
// (R11) single mode: one initiate arms one trigger; host re-initiates
// (R12) continuous setting takes 0 or 1, its query returns 0 or 1
// (R13) abort cancels trigger and restores pending levels to immediate ones
// (R14) abort clears waiting bit; continuous mode re-arms and sets it
// (R15) abort runs at power-on, recall and reset commands
// (R16) serial port fixed at 19200 baud, 8N1, no flow control
// (R17) first port with traffic after power-on becomes active
// (R18) other port ignored until active port idle 5 minutes
// (R19) service summary bit 6 is unlatched, set while service needed
// (R20) service summary is OR of status byte masked by enable
// (R21) event summary set when enabled event status bit is set
// (R22) message available while an unread response is held
// (R23) event status read clears it; status byte read does not
// (R24) questionable register is live, unlatched, read-only
// (R25) questionable bits 6 and 10 to 15 read zero
`timescale 1ns/1ps
`default_nettype none
`include "supply_status_map.svh"

module error_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst_b,
   input  wire logic             i_flush,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data,
   output logic [$clog2(DEPTH):0] o_count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   wire              push = i_in_valid & o_in_ready;
   wire              pop  = i_out_ready & o_out_valid;

   assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
   assign o_out_valid = (count_r != '0);
   assign o_out_data  = mem_r[rd_ptr_r];
   assign o_count     = count_r;

   always_ff @(posedge i_clk_sys) begin
      if (push)
         mem_r[wr_ptr_r] <= i_in_data;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b || i_flush) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_r + AW'(push);
         rd_ptr_r <= rd_ptr_r + AW'(pop);
         count_r  <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module supply_status_trigger_control #(
   parameter logic [39:0] IDLE_CYCLES = 40'(`SST_IDLE_MIN) * 40'(`SST_SEC_PER_MIN)
                                      * 40'(`SST_CLK_MHZ) * 40'd1000000,
   parameter logic [7:0]  FW_REV      = 8'h10,   // arbitrary
   parameter logic [7:0]  HW_REV      = 8'h10    // arbitrary
) (
   input  wire logic                         i_clk_sys,
   input  wire logic                         i_rst_b,
   input  wire logic                         i_serial_activity,
   input  wire logic                         i_gpib_activity,
   input  wire logic                         i_cmd_valid,
   input  wire supply_status_pkg::port_type  i_cmd_port,
   input  wire supply_status_pkg::cmd_type   i_cmd_code,
   input  wire logic [7:0]                   i_cmd_arg,
   input  wire logic                         i_dev_err_valid,
   input  wire logic [15:0]                  i_dev_err_code,
   input  wire logic                         i_rsp_ready,
   output logic                              o_rsp_valid,
   output supply_status_pkg::rsp_type        o_rsp_kind,
   output logic [15:0]                       o_rsp_value,
   input  wire logic                         i_overvoltage_trip,
   input  wire logic                         i_overcurrent_trip,
   input  wire logic                         i_phase_balance_trip,
   input  wire logic                         i_program_line_trip,
   input  wire logic                         i_overtemperature_trip,
   input  wire logic                         i_fuse_trip,
   input  wire logic                         i_alarm_trip,
   input  wire logic                         i_safety_lockout_flag,
   input  wire logic                         i_remote_control_flag,
   output logic [15:0]                       o_questionable_condition,
   output logic [7:0]                        o_status_byte,
   output logic [7:0]                        o_event_status,
   output logic                              o_waiting_for_trigger,
   output logic                              o_continuous_arm_setting,
   output logic                              o_apply_levels,
   output logic                              o_restore_levels,
   output logic                              o_oper_clear,
   output supply_status_pkg::port_type       o_active_port,
   output logic [15:0]                       o_uart_baud_div
);
   import supply_status_pkg::*;

   function automatic logic [7:0] err_group(input logic [15:0] code);
      logic [15:0] mag;
      mag = 16'h0000 - code;
      err_group = 8'h00;
      if (mag >= 16'd100 && mag <= 16'd199) err_group[`SST_ESR_CMD_ERR] = 1'b1;
      if (mag >= 16'd200 && mag <= 16'd299) err_group[`SST_ESR_EXE_ERR] = 1'b1;
      if (mag >= 16'd300 && mag <= 16'd399) err_group[`SST_ESR_DEV_ERR] = 1'b1;
      if (mag >= 16'd400 && mag <= 16'd499) err_group[`SST_ESR_QRY_ERR] = 1'b1;
   endfunction

   port_type    port_r;
   port_type    port_nxt;
   logic [39:0] idle_r;
   trig_type    trig_r;
   trig_type    trig_nxt;
   logic        cont_r;
   logic        cont_nxt;
   logic [7:0]  esr_r;
   logic [7:0]  ese_r;
   logic [7:0]  sre_r;
   logic [7:0]  stb_r;
   logic [15:0] ques_r;
   logic        rsp_valid_r;
   rsp_type     rsp_kind_r;
   logic [15:0] rsp_value_r;
   logic        apply_r;
   logic        restore_r;
   logic        oper_clr_r;
   logic [15:0] baud_r;

   // port selection
   wire serial_hit = i_serial_activity;
   wire gpib_hit   = i_gpib_activity;
   wire active_hit = (port_r == PORT_SERIAL) ? serial_hit : (port_r == PORT_GPIB) ? gpib_hit : 1'b0;
   wire idle_done  = (port_r != PORT_NONE) && (idle_r >= IDLE_CYCLES - 40'd1);   // R18
   assign port_nxt = (port_r == PORT_NONE) ? (serial_hit ? PORT_SERIAL :          // R17
                                              gpib_hit ? PORT_GPIB : PORT_NONE)
                   : (idle_done && !active_hit) ? PORT_NONE : port_r;            // R18

   // command acceptance; other port's traffic is dropped
   wire cmd_take  = i_cmd_valid && (i_cmd_port == port_r) && (port_r != PORT_NONE); // R18
   wire c_trig    = cmd_take && (i_cmd_code == CMD_TRIG);
   wire c_init    = cmd_take && (i_cmd_code == CMD_INIT);
   wire c_abort   = cmd_take && (i_cmd_code == CMD_ABORT || i_cmd_code == CMD_RECALL
                                 || i_cmd_code == CMD_RESET);                    // R15
   wire c_cls     = cmd_take && (i_cmd_code == CMD_CLS);
   wire cont_bad  = (i_cmd_arg > 8'h01);
   wire c_cont    = cmd_take && (i_cmd_code == CMD_CONT_SET) && !cont_bad;       // R12
   wire is_query  = (i_cmd_code == CMD_ESR_Q) || (i_cmd_code == CMD_ESE_Q) || (i_cmd_code == CMD_SRE_Q)
                 || (i_cmd_code == CMD_STB_Q) || (i_cmd_code == CMD_QUES_Q) || (i_cmd_code == CMD_VERS_Q)
                 || (i_cmd_code == CMD_ERR_Q) || (i_cmd_code == CMD_CONT_Q);
   wire rsp_pop   = rsp_valid_r && i_rsp_ready;
   // one response in flight; a query before it is read is a query error
   wire query_err = cmd_take && is_query && rsp_valid_r && !rsp_pop;
   wire rsp_load  = cmd_take && is_query && !query_err && !c_cls;

   // internal errors
   wire [15:0] int_code = query_err                        ? `SST_ERR_QUERY :   // R07
                          (i_cmd_code == CMD_BAD_SYN)      ? `SST_ERR_SYNTAX :
                          (i_cmd_code == CMD_BAD_PARAM)    ? `SST_ERR_PARAMS :
                          (i_cmd_code == CMD_CONT_SET)     ? `SST_ERR_RANGE :
                                                             `SST_ERR_COMMAND;
   wire int_err   = cmd_take && (query_err || i_cmd_code == CMD_BAD_GEN || i_cmd_code == CMD_BAD_SYN
                                 || i_cmd_code == CMD_BAD_PARAM
                                 || (i_cmd_code == CMD_CONT_SET && cont_bad));
   // internal error takes the slot; a colliding device error is lost
   wire        push_req  = int_err || i_dev_err_valid;
   wire [15:0] push_code = int_err ? int_code : i_dev_err_code;

   // error queue
   wire        q_in_ready;
   wire        q_out_valid;
   wire [15:0] q_out_data;
   wire [4:0]  q_count;
   wire        q_last    = (q_count == 5'(`SST_ERRQ_DEPTH - 1));
   wire [15:0] q_in_data = q_last ? `SST_ERR_OVERFLOW : push_code;                // R05
   // full queue: new errors are refused at the fifo and only reach the event status
   wire        q_push    = push_req && q_in_ready && !c_cls;
   wire        q_pop     = rsp_load && (i_cmd_code == CMD_ERR_Q);                 // R03

   error_fifo #(
      .WIDTH (`SST_ERRQ_WIDTH),
      .DEPTH (`SST_ERRQ_DEPTH)
   ) u_errq (
      .i_clk_sys   (i_clk_sys),
      .i_rst_b     (i_rst_b),
      .i_flush     (c_cls),
      .i_in_valid  (q_push),
      .o_in_ready  (q_in_ready),
      .i_in_data   (q_in_data),
      .o_out_valid (q_out_valid),
      .i_out_ready (q_pop),
      .o_out_data  (q_out_data),
      .o_count     (q_count)
   );

   // trigger state
   wire trig_fire = c_trig && (trig_r == TRIG_ARMED);                             // R10
   assign cont_nxt = (cmd_take && i_cmd_code == CMD_RESET) ? 1'b0 : c_cont ? i_cmd_arg[0] : cont_r;
   always_comb begin
      trig_nxt = trig_r;
      unique case (trig_r)
         TRIG_IDLE: begin
            if (c_init)
               trig_nxt = TRIG_ARMED;                                             // R11
            else if (c_abort && cont_r)
               trig_nxt = TRIG_ARMED;                                             // R14
         end
         TRIG_ARMED: begin
            if (c_abort)
               trig_nxt = cont_r ? TRIG_ARMED : TRIG_IDLE;                        // R14
            else if (trig_fire)
               trig_nxt = cont_r ? TRIG_ARMED : TRIG_IDLE;                        // R09 R11
         end
      endcase
   end

   // status reporting
   wire [7:0] esr_set  = push_req ? err_group(push_code) : 8'h00;                 // R06
   wire       esr_read = rsp_load && (i_cmd_code == CMD_ESR_Q);
   wire [7:0] esr_nxt  = ((esr_read || c_cls) ? 8'h00 : esr_r) | esr_set;         // R23
   wire       mav      = rsp_valid_r;                                             // R22
   wire       esb      = |(esr_r & ese_r);                                        // R21
   wire [7:0] stb_base = {1'b0, 1'b0, esb, mav, 4'h0};
   wire       mss      = |(stb_base & sre_r);                                     // R19 R20
   wire [7:0] stb_nxt  = stb_base | (8'(mss) << `SST_STB_MSS);
   wire [15:0] ques_nxt = ({6'h00,
                            i_remote_control_flag, i_safety_lockout_flag, i_alarm_trip, 1'b0,
                            i_fuse_trip, i_overtemperature_trip, i_program_line_trip,
                            i_phase_balance_trip, i_overcurrent_trip, i_overvoltage_trip})
                          & `SST_QUES_USED_MASK;                                  // R01 R24 R25

   // response selection
   wire [15:0] err_val  = q_out_valid ? q_out_data : `SST_ERR_NONE;               // R04
   wire [15:0] rsp_nxt  = (i_cmd_code == CMD_ESR_Q)  ? {8'h00, esr_r} :
                          (i_cmd_code == CMD_ESE_Q)  ? {8'h00, ese_r} :
                          (i_cmd_code == CMD_SRE_Q)  ? {8'h00, sre_r} :
                          (i_cmd_code == CMD_STB_Q)  ? {8'h00, stb_r} :
                          (i_cmd_code == CMD_QUES_Q) ? ques_r :
                          (i_cmd_code == CMD_VERS_Q) ? {FW_REV, HW_REV} :         // R02
                          (i_cmd_code == CMD_ERR_Q)  ? err_val :                  // R03
                                                       {15'h0000, cont_r};        // R12
   wire rsp_type kind_nxt = (i_cmd_code == CMD_ERR_Q) ? RSP_ERR :
                            (i_cmd_code == CMD_VERS_Q) ? RSP_VERS : RSP_NUM;

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         port_r <= PORT_NONE;
         idle_r <= 40'h00_0000_0000;
      end else begin
         port_r <= port_nxt;
         idle_r <= (port_nxt != port_r || active_hit) ? 40'h00_0000_0000 : idle_r + 40'h00_0000_0001;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         trig_r     <= TRIG_IDLE;
         cont_r     <= 1'b0;
         apply_r    <= 1'b0;
         restore_r  <= 1'b1;                                                      // R15
         oper_clr_r <= 1'b0;
      end else begin
         trig_r     <= trig_nxt;
         cont_r     <= cont_nxt;
         apply_r    <= trig_fire && !c_abort;                                     // R08
         restore_r  <= c_abort;                                                   // R13
         oper_clr_r <= trig_fire && !c_abort;                                     // R09
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         esr_r  <= `SST_ESR_RESET;
         ese_r  <= 8'h00;
         sre_r  <= 8'h00;
         stb_r  <= 8'h00;
         ques_r <= 16'h0000;
         baud_r <= 16'h0000;
      end else begin
         esr_r  <= esr_nxt;
         ese_r  <= (cmd_take && i_cmd_code == CMD_ESE_SET) ? i_cmd_arg : ese_r;
         sre_r  <= (cmd_take && i_cmd_code == CMD_SRE_SET) ? i_cmd_arg : sre_r;
         stb_r  <= stb_nxt;
         ques_r <= ques_nxt;
         // line rate for the uart; framing is fixed 8N1 without handshake
         baud_r <= 16'(`SST_CLK_MHZ * 1000000 / `SST_UART_BAUD);                  // R16
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         rsp_valid_r <= 1'b0;
         rsp_kind_r  <= RSP_NUM;
         rsp_value_r <= 16'h0000;
      end else begin
         rsp_valid_r <= rsp_load || (rsp_valid_r && !rsp_pop && !c_cls);          // R22
         if (rsp_load) begin
            rsp_kind_r  <= kind_nxt;
            rsp_value_r <= rsp_nxt;
         end
      end
   end

   assign o_rsp_valid              = rsp_valid_r;
   assign o_rsp_kind               = rsp_kind_r;
   assign o_rsp_value              = rsp_value_r;
   assign o_questionable_condition = ques_r;
   assign o_status_byte            = stb_r;
   assign o_event_status           = esr_r;
   assign o_waiting_for_trigger    = (trig_r == TRIG_ARMED);
   assign o_continuous_arm_setting = cont_r;
   assign o_apply_levels           = apply_r;
   assign o_restore_levels         = restore_r;
   assign o_oper_clear             = oper_clr_r;
   assign o_active_port            = port_r;
   assign o_uart_baud_div          = baud_r;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);

   a_ques_unused_zero: assert property (o_questionable_condition[6] == 1'b0
      && o_questionable_condition[15:10] == 6'h00) else $error("unused questionable bit set"); // R25
   a_ques_live_trip: assert property (i_overvoltage_trip |=> o_questionable_condition[0])
      else $error("overvoltage not reported"); // R01
   a_trig_ignored: assert property (c_trig && trig_r == TRIG_IDLE |=> !o_apply_levels)
      else $error("trigger acted while unarmed"); // R10
   a_trig_apply: assert property (trig_fire && !c_abort |=> o_apply_levels && o_oper_clear)
      else $error("armed trigger did not apply levels"); // R08
   a_single_shot: assert property (trig_fire && !c_abort && !cont_r |=> !o_waiting_for_trigger)
      else $error("single mode stayed armed"); // R11
   a_cont_rearm: assert property (trig_fire && cont_r && !(cmd_take && i_cmd_code == CMD_RESET)
      |=> o_waiting_for_trigger) else $error("continuous mode did not re-arm"); // R09
   a_abort_restore: assert property (c_abort |=> o_restore_levels && (o_waiting_for_trigger == $past(cont_r)))
      else $error("abort did not restore"); // R13
   a_mss_or: assert property (o_status_byte[6] == |($past(stb_base) & $past(sre_r)))
      else $error("service summary mismatch"); // R20
   // stb lags rsp valid a cycle
   a_mav_tracks: assert property (rsp_load |=> o_rsp_valid ##1 o_status_byte[4])
      else $error("message available missing"); // R22
   a_esr_clear_read: assert property (esr_read && !push_req |=> o_event_status == 8'h00)
      else $error("event status not cleared on read"); // R23
   a_empty_err: assert property (!q_out_valid && rsp_load && i_cmd_code == CMD_ERR_Q
      |=> o_rsp_value == `SST_ERR_NONE) else $error("empty queue not zero"); // R04
   a_overflow_last: assert property (q_push && q_last && !q_pop |=> !q_in_ready)
      else $error("overflow entry not last"); // R05

   c_trigger_fire: cover property (trig_fire);
   c_queue_full: cover property (q_push && q_last);
   c_port_switch: cover property (idle_done ##1 port_r == PORT_NONE);
   c_cont_abort: cover property (c_abort && cont_r);
endmodule
`default_nettype wire

// ---- supply_status_map.svh ----
`ifndef SUPPLY_STATUS_MAP_SVH
`define SUPPLY_STATUS_MAP_SVH
// questionable condition bit positions
`define SST_QUES_OVERVOLTAGE   0
`define SST_QUES_OVERCURRENT   1
`define SST_QUES_PHASE_BAL     2
`define SST_QUES_PROGRAM_LINE  3
`define SST_QUES_OVERTEMP      4
`define SST_QUES_FUSE          5
`define SST_QUES_ALARM         7
`define SST_QUES_LOCKOUT       8
`define SST_QUES_REMOTE        9
`define SST_QUES_USED_MASK     16'h03BF
// standard event status bits
`define SST_ESR_CMD_ERR        5
`define SST_ESR_EXE_ERR        4
`define SST_ESR_DEV_ERR        3
`define SST_ESR_QRY_ERR        2
`define SST_ESR_RESET          8'h80
// status byte bits
`define SST_STB_MAV            4
`define SST_STB_ESB            5
`define SST_STB_MSS            6
// error codes, two's complement
`define SST_ERR_NONE           16'h0000
`define SST_ERR_COMMAND        16'hFF9C
`define SST_ERR_SYNTAX         16'hFF9A
`define SST_ERR_PARAMS         16'hFF94
`define SST_ERR_RANGE          16'hFF22
`define SST_ERR_OVERFLOW       16'hFEA2
`define SST_ERR_QUERY          16'hFE70
// error queue
`define SST_ERRQ_DEPTH         16
`define SST_ERRQ_WIDTH         16
// serial port settings
`define SST_UART_BAUD          19200
`define SST_UART_DATA_BITS     8
`define SST_UART_STOP_BITS     1
`define SST_UART_PARITY        0
`define SST_UART_FLOW          0
// timing
`define SST_CLK_MHZ            250
`define SST_IDLE_MIN           5
`define SST_SEC_PER_MIN        60
`endif

// ---- supply_status_pkg.sv ----
package supply_status_pkg;
   typedef enum logic [4:0] {
      CMD_NOP       = 5'h00,
      CMD_TRIG      = 5'h01,
      CMD_INIT      = 5'h02,
      CMD_CONT_SET  = 5'h03,
      CMD_CONT_Q    = 5'h04,
      CMD_ABORT     = 5'h05,
      CMD_RECALL    = 5'h06,
      CMD_RESET     = 5'h07,
      CMD_CLS       = 5'h08,
      CMD_ESR_Q     = 5'h09,
      CMD_ESE_SET   = 5'h0A,
      CMD_ESE_Q     = 5'h0B,
      CMD_SRE_SET   = 5'h0C,
      CMD_SRE_Q     = 5'h0D,
      CMD_STB_Q     = 5'h0E,
      CMD_QUES_Q    = 5'h0F,
      CMD_VERS_Q    = 5'h10,
      CMD_ERR_Q     = 5'h11,
      CMD_BAD_GEN   = 5'h12,
      CMD_BAD_SYN   = 5'h13,
      CMD_BAD_PARAM = 5'h14
   } cmd_type;
   typedef enum logic [1:0] {
      PORT_NONE   = 2'b00,
      PORT_SERIAL = 2'b01,
      PORT_GPIB   = 2'b11
   } port_type;
   typedef enum logic {
      TRIG_IDLE  = 1'b0,
      TRIG_ARMED = 1'b1
   } trig_type;
   typedef enum logic [1:0] {
      RSP_NUM  = 2'b00,
      RSP_ERR  = 2'b01,
      RSP_VERS = 2'b11
   } rsp_type;
endpackage

// ---- host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rsp_valid,
   input  wire logic [15:0]           i_rsp_value,
   output logic                       o_cmd_valid,
   output supply_status_pkg::cmd_type o_cmd_code,
   output logic [7:0]                 o_cmd_arg,
   output logic                       o_rsp_ready
);
   import supply_status_pkg::*;
   localparam int BAUD = 19200;
   int lag = 0;
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd_code  = CMD_NOP;
      o_cmd_arg   = 8'h00;
      o_rsp_ready = 1'b0;
   end
   // quiet cycle after each command so valid is never driven twice in one step
   task automatic send(input cmd_type c, input logic [7:0] a);
      o_cmd_valid <= 1'b1;
      o_cmd_code  <= c;
      o_cmd_arg   <= a;
      @(posedge i_clk_sys);
      o_cmd_valid <= 1'b0;
      @(posedge i_clk_sys);
   endtask
   // lag models a slow reader leaving the answer unread
   task automatic take(output logic [15:0] v);
      for (int n = 0; n < 8 && i_rsp_valid !== 1'b1; n++) @(posedge i_clk_sys);
      repeat (lag) @(posedge i_clk_sys);
      v = i_rsp_value;
      o_rsp_ready <= 1'b1;
      @(posedge i_clk_sys);
      o_rsp_ready <= 1'b0;
      @(posedge i_clk_sys);
   endtask
endmodule
`default_nettype wire

// ---- test_supply_status_trigger_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_supply_status_trigger_control;
   import supply_status_pkg::*;
   logic        clk, rst_b, ser, gpib, cv, dv, rdy, rv, waiting_for_trigger, cont, app, rlv, oclr;
   logic [7:0]  arg, stb, esr;
   logic [8:0]  trips;
   logic [15:0] dcode, rval, ques, baud, v;
   cmd_type     code;
   rsp_type     kind;
   port_type    port, act;
   int          mismatches = 0, total_checks = 0, napp = 0, nrst = 0, nclr = 0;
   supply_status_trigger_control #(.IDLE_CYCLES(40'd20), .FW_REV(8'h21), .HW_REV(8'h34)) dut (
      .i_clk_sys(clk), .i_rst_b(rst_b), .i_serial_activity(ser), .i_gpib_activity(gpib), .i_cmd_valid(cv),
      .i_cmd_port(port), .i_cmd_code(code), .i_cmd_arg(arg), .i_dev_err_valid(dv), .i_dev_err_code(dcode),
      .i_rsp_ready(rdy), .o_rsp_valid(rv), .o_rsp_kind(kind), .o_rsp_value(rval), .i_overvoltage_trip(trips[0]),
      .i_overcurrent_trip(trips[1]), .i_phase_balance_trip(trips[2]), .i_program_line_trip(trips[3]),
      .i_overtemperature_trip(trips[4]), .i_fuse_trip(trips[5]), .i_alarm_trip(trips[6]),
      .i_safety_lockout_flag(trips[7]), .i_remote_control_flag(trips[8]), .o_questionable_condition(ques),
      .o_status_byte(stb), .o_event_status(esr), .o_waiting_for_trigger(waiting_for_trigger), .o_continuous_arm_setting(cont),
      .o_apply_levels(app), .o_restore_levels(rlv), .o_oper_clear(oclr), .o_active_port(act),
      .o_uart_baud_div(baud));
   host_model host (.i_clk_sys(clk), .i_rsp_valid(rv), .i_rsp_value(rval), .o_cmd_valid(cv),
      .o_cmd_code(code), .o_cmd_arg(arg), .o_rsp_ready(rdy));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // pulses last one cycle, so count them instead of sampling
   always @(posedge clk) begin
      napp += app;
      nrst += rlv;
      nclr += oclr;
   end
   task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic cmd(input cmd_type c, input logic [7:0] a = 8'h00);
      host.send(c, a);
   endtask
   task automatic ask(input cmd_type c, input logic [15:0] exp, input string name);
      host.send(c, 8'h00);
      host.take(v);
      chk(name, v, exp);
   endtask
   task automatic t_ques();
      int pos [9] = '{0, 1, 2, 3, 4, 5, 7, 8, 9};
      for (int k = 0; k < 9; k++) begin
         trips <= 9'(1 << k);
         idle(3);
         chk("ques_bit", ques, 16'(1 << pos[k]));
      end
      trips <= 9'h1FF;
      idle(3);
      chk("ques_all", ques, 16'h03BF);
      ask(CMD_QUES_Q, 16'h03BF, "ques_read");
      trips <= 9'h000;
      idle(3);
      chk("ques_live", ques, 16'h0000);
      $display("test ques done");
   endtask
   task automatic t_trig();
      int a;
      int c;
      a = napp;
      c = nclr;
      cmd(CMD_TRIG);
      idle(2);
      chk("trig_unarmed", 16'(napp - a), 16'h0000);
      cmd(CMD_INIT);
      chk("armed", 16'(waiting_for_trigger), 16'h0001);
      cmd(CMD_TRIG);
      idle(2);
      chk("apply", 16'(napp - a), 16'h0001);
      chk("oper_clear", 16'(nclr - c), 16'h0001);
      chk("single_done", 16'(waiting_for_trigger), 16'h0000);
      cmd(CMD_TRIG);
      idle(2);
      chk("trig_again", 16'(napp - a), 16'h0001);
      $display("test trig done");
   endtask
   task automatic t_cont();
      cmd_type ab [3] = '{CMD_ABORT, CMD_RECALL, CMD_RESET};
      int a;
      cmd(CMD_CONT_SET, 8'h01);
      ask(CMD_CONT_Q, 16'h0001, "cont_query");
      cmd(CMD_INIT);
      a = napp;
      cmd(CMD_TRIG);
      idle(2);
      chk("cont_apply", 16'(napp - a), 16'h0001);
      chk("cont_rearm", 16'(waiting_for_trigger), 16'h0001);
      foreach (ab[i]) begin
         a = nrst;
         cmd(ab[i]);
         idle(2);
         chk("abort_restore", 16'(nrst - a), 16'h0001);
         chk("abort_wait", 16'(waiting_for_trigger), 16'h0001);
      end
      ask(CMD_CONT_Q, 16'h0000, "cont_off");
      $display("test cont done");
   endtask
   task automatic t_err();
      logic [15:0] codes [5] = '{16'hFF9C, 16'hFF9A, 16'hFF94, 16'hFF22, 16'hFED4};
      cmd(CMD_CLS);
      cmd(CMD_BAD_GEN);
      cmd(CMD_BAD_SYN);
      cmd(CMD_BAD_PARAM);
      cmd(CMD_CONT_SET, 8'h02);
      dcode <= 16'hFED4;
      dv    <= 1'b1;
      idle(1);
      dv    <= 1'b0;
      idle(2);
      chk("esr_groups", 16'(esr), 16'h0038);
      foreach (codes[i]) ask(CMD_ERR_Q, codes[i], "err_order");
      cmd(CMD_ERR_Q);
      cmd(CMD_STB_Q);
      host.take(v);
      chk("err_empty", v, 16'h0000);
      chk("esr_query", 16'(esr), 16'h003C);
      ask(CMD_ERR_Q, 16'hFE70, "err_query");
      cmd(CMD_CLS);
      repeat (17) cmd(CMD_BAD_GEN);
      host.lag = 2;
      for (int i = 0; i < 16; i++) ask(CMD_ERR_Q, (i == 15) ? 16'hFEA2 : 16'hFF9C, "err_fill");
      ask(CMD_ERR_Q, 16'h0000, "err_drained");
      $display("test err done");
   endtask
   task automatic t_status();
      cmd(CMD_CLS);
      cmd(CMD_ESE_SET, 8'h20);
      cmd(CMD_SRE_SET, 8'h20);
      cmd(CMD_BAD_GEN);
      idle(3);
      chk("esb_mss", 16'(stb), 16'h0060);
      ask(CMD_ESR_Q, 16'h0020, "esr_read");
      idle(3);
      chk("esr_cleared", 16'(stb), 16'h0000);
      cmd(CMD_SRE_SET, 8'h10);
      cmd(CMD_STB_Q);
      idle(3);
      chk("mav", 16'(stb), 16'h0050);
      host.take(v);
      idle(3);
      chk("mav_gone", 16'(stb), 16'h0000);
      ask(CMD_VERS_Q, 16'h2134, "version");
      chk("rsp_kind", 16'(kind), 16'(RSP_VERS));
      $display("test status done");
   endtask
   task automatic t_port();
      port <= PORT_GPIB;
      gpib <= 1'b1;
      cmd(CMD_CONT_SET, 8'h01);
      idle(2);
      chk("gpib_ignored", 16'(cont), 16'h0000);
      ser  <= 1'b0;
      gpib <= 1'b0;
      idle(30);
      chk("port_free", 16'(act), 16'h0000);
      gpib <= 1'b1;
      idle(2);
      chk("port_gpib", 16'(act), 16'h0003);
      cmd(CMD_CONT_SET, 8'h01);
      idle(2);
      chk("gpib_taken", 16'(cont), 16'h0001);
      $display("test port done");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #40000;
      mismatches++;
      final_report();
   end
   initial begin
      rst_b = 1'b0;
      ser   = 1'b0;
      gpib  = 1'b0;
      dv    = 1'b0;
      dcode = 16'h0000;
      trips = 9'h000;
      port  = PORT_SERIAL;
      idle(5);
      chk("reset_restore", 16'(rlv), 16'h0001);
      idle(5);
      rst_b <= 1'b1;
      ser   <= 1'b1;
      idle(3);
      chk("baud_div", baud, 16'h32DC);
      chk("port_first", 16'(act), 16'h0001);
      t_ques();
      t_trig();
      t_cont();
      t_err();
      t_status();
      t_port();
      final_report();
   end
endmodule
`default_nettype wire
